// ### rtl/ictsc_defines.svh
`ifndef ICTSC_DEFINES_SVH
`define ICTSC_DEFINES_SVH

// ********************************************************
// register map, byte addresses
// ********************************************************
`define ICTSC_OFS_CTRL   5'h00
`define ICTSC_OFS_CNT    5'h04
`define ICTSC_OFS_CAP0   5'h08
`define ICTSC_OFS_CAP1   5'h0c
`define ICTSC_OFS_STAT   8'h80
`define ICTSC_OFS_MASK   8'h84

// ********************************************************
// field layout and reset values
// ********************************************************
`define ICTSC_CTRL_W     12
`define ICTSC_CTRL_RST   12'h000
`define ICTSC_EV_OVF     0
`define ICTSC_EV_CAP0    1
`define ICTSC_EV_CAP1    2
`define ICTSC_EV_PER_CH  3

`endif

// ### rtl/ictsc_pkg.sv
package ictsc_pkg;

  typedef enum logic [1:0] {
    ICTSC_EDGE_RISE = 2'b00,
    ICTSC_EDGE_FALL = 2'b01,
    ICTSC_EDGE_BOTH = 2'b10
  } ictsc_edge_t;

  typedef enum logic {
    ICTSC_SRC_UNDIV = 1'b0,
    ICTSC_SRC_PIN   = 1'b1
  } ictsc_src_t;

  typedef enum logic [1:0] {
    ICTSC_MODE_INDEP  = 2'b00,
    ICTSC_MODE_MASTER = 2'b01,
    ICTSC_MODE_FOLLOW = 2'b10
  } ictsc_mode_t;

  typedef enum logic [1:0] {
    ICTSC_CLR_NONE = 2'b00,
    ICTSC_CLR_CAP0 = 2'b01,
    ICTSC_CLR_CAP1 = 2'b10,
    ICTSC_CLR_SYNC = 2'b11
  } ictsc_clr_t;

  typedef struct packed {
    ictsc_edge_t cap_edge1;
    ictsc_edge_t cap_edge0;
    ictsc_clr_t  clr;
    ictsc_mode_t mode;
    ictsc_edge_t cnt_edge;
    ictsc_src_t  src;
    logic        run;
  } ictsc_ctrl_t;

endpackage

// ### rtl/ictsc_sync3.sv
`timescale 1ns/1ps

// three-stage pin synchroniser; a change counts once stages 2 and 3 agree
module ictsc_sync3 (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      lvl_q <= s3_q;
    end
  end

  assign rise = (s2_q == s3_q) & s3_q & ~lvl_q;
  assign fall = (s2_q == s3_q) & ~s3_q & lvl_q;

endmodule

// ### rtl/ictsc_capmem.sv
`timescale 1ns/1ps

// capture word store; every word has its own write port, read is registered
module ictsc_capmem #(
  parameter int WORDS = 8,
  parameter int WIDTH = 16,
  parameter int AW    = 3
) (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic [WORDS-1:0]       we,
  input  wire logic [WORDS*WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]          raddr,
  output logic      [WIDTH-1:0]       rdata_q
);

  logic [WIDTH-1:0] mem_q [WORDS];

  initial begin
    if (WORDS > (1 << AW)) $error("capmem address too narrow");
  end

  for (genvar w = 0; w < WORDS; w++) begin : g_word
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        mem_q[w] <= '0;
      end else if (we[w]) begin
        mem_q[w] <= wdata[w*WIDTH +: WIDTH];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= (32'(raddr) < WORDS) ? mem_q[raddr] : '0;
    end
  end

endmodule

// ### rtl/ictsc_top.sv
// Decided for this implementation: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "ictsc_defines.svh"

module ictsc_top #(
  parameter int   NCH          = 4,
  parameter int   CW           = 16,
  parameter logic RUN_AT_RESET = 1'b1
) (
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic                 hreadyout,
  output logic      [31:0]     hrdata,
  output logic                 hresp,
  input  wire logic [NCH-1:0]  count_pin,
  input  wire logic [2*NCH-1:0] cap_pin,
  output logic                 irq
);

  localparam int NEV = `ICTSC_EV_PER_CH * NCH;
  localparam int MAW = $clog2(2 * NCH);

  initial begin
    if (NCH != 2 && NCH != 4) $error("NCH must be 2 or 4");
    if (CW < 2 || CW > 32) $error("CW must be 2 to 32");
  end

  // ********************************************************
  // address decode
  // ********************************************************
  function automatic logic ch_hit(input logic [31:0] a, input int ch,
                                  input logic [4:0] ofs);
    ch_hit = (a[31:8] == 24'h0) && (32'(a[7:5]) == ch) && (a[4:0] == ofs);
  endfunction

  function automatic logic glb_hit(input logic [31:0] a,
                                   input logic [7:0] ofs);
    glb_hit = (a[31:8] == 24'h0) && (a[7:0] == ofs);
  endfunction

  // ********************************************************
  // ahb-lite slave: one wait state on every transfer
  // ********************************************************
  logic        acc;
  logic        pend_q;
  logic        wr_q;
  logic [31:0] addr_q;
  logic        hready_q;
  logic [31:0] hrdata_q;
  logic        wr;

  assign acc = hsel & htrans[1] & hready;
  assign wr  = pend_q & wr_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q   <= 1'b0;
      wr_q     <= 1'b0;
      addr_q   <= 32'h0;
      hready_q <= 1'b1;
    end else begin
      pend_q   <= acc;
      hready_q <= ~acc;
      if (acc) begin
        wr_q   <= hwrite;
        addr_q <= haddr;
      end
    end
  end

  assign hreadyout = hready_q;
  assign hrdata    = hrdata_q;
  assign hresp     = 1'b0;

  // ********************************************************
  // per-channel state
  // ********************************************************
  ictsc_pkg::ictsc_ctrl_t ctrl_q [NCH];
  logic [CW-1:0]          cnt_q  [NCH];
  logic [NCH-1:0]         cnt_wr;
  logic [NCH-1:0]         tick;
  logic [NCH-1:0]         own_fire;
  logic [NCH-1:0]         sync_ok;
  logic [NCH-1:0]         pair_on;
  logic [NCH-1:0]         clr_now;
  logic [NCH-1:0]         load;
  logic [NCH-1:0]         cnt_rise;
  logic [NCH-1:0]         cnt_fall;
  logic [2*NCH-1:0]       cap_rise;
  logic [2*NCH-1:0]       cap_fall;
  logic [2*NCH-1:0]       cap_ev;
  logic [2*NCH*CW-1:0]    cap_data;
  logic [NEV-1:0]         ev_set;
  logic [NEV-1:0]         status_q;
  logic [CW-1:0]          cap_rdata;

  function automatic logic edge_ok(input ictsc_pkg::ictsc_edge_t e,
                                   input logic r, input logic f);
    case (e)
      ictsc_pkg::ICTSC_EDGE_FALL: edge_ok = f;
      ictsc_pkg::ICTSC_EDGE_BOTH: edge_ok = r | f;
      default:                    edge_ok = r;
    endcase
  endfunction

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    localparam int P = c ^ 1; // partner fixed: a-b, c-d
    ictsc_pkg::ictsc_ctrl_t wctl;

    ictsc_sync3 u_cnt_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin     (count_pin[c]),
      .rise    (cnt_rise[c]),
      .fall    (cnt_fall[c])
    );

    for (genvar k = 0; k < 2; k++) begin : g_cap
      ictsc_sync3 u_cap_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (cap_pin[2*c+k]),
        .rise    (cap_rise[2*c+k]),
        .fall    (cap_fall[2*c+k])
      );
      assign cap_data[(2*c+k)*CW +: CW] = cnt_q[c];
    end

    assign cap_ev[2*c]   = ctrl_q[c].run &
        edge_ok(ctrl_q[c].cap_edge0, cap_rise[2*c], cap_fall[2*c]);
    assign cap_ev[2*c+1] = ctrl_q[c].run &
        edge_ok(ctrl_q[c].cap_edge1, cap_rise[2*c+1], cap_fall[2*c+1]);

    // undivided clock counts every cycle, always on the rising edge
    assign tick[c] = ctrl_q[c].run &
        ((ctrl_q[c].src == ictsc_pkg::ICTSC_SRC_UNDIV) |
         edge_ok(ctrl_q[c].cnt_edge, cnt_rise[c], cnt_fall[c]));

    // local clear from a selected capture register
    assign own_fire[c] =
        ((ctrl_q[c].clr == ictsc_pkg::ICTSC_CLR_CAP0) & cap_ev[2*c]) |
        ((ctrl_q[c].clr == ictsc_pkg::ICTSC_CLR_CAP1) & cap_ev[2*c+1]);

    // a follower only joins while its partner is master
    assign sync_ok[c] = (ctrl_q[c].mode == ictsc_pkg::ICTSC_MODE_MASTER) |
        ((ctrl_q[c].mode == ictsc_pkg::ICTSC_MODE_FOLLOW) &
         (ctrl_q[P].mode == ictsc_pkg::ICTSC_MODE_MASTER));
    assign pair_on[c] = sync_ok[c] & sync_ok[P];

    // disabled clearing never matches any term here
    assign clr_now[c] = own_fire[c] |
        ((ctrl_q[c].clr == ictsc_pkg::ICTSC_CLR_SYNC) & pair_on[c] &
         own_fire[P]);

    assign cnt_wr[c] = wr & ch_hit(addr_q, c, `ICTSC_OFS_CNT);
    assign load[c]   = cnt_wr[c] | (pair_on[c] & cnt_wr[P]);

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cnt_q[c] <= '0;
      end else if (load[c]) begin
        cnt_q[c] <= hwdata[CW-1:0];
      end else if (clr_now[c]) begin
        cnt_q[c] <= '0;
      end else if (tick[c]) begin
        cnt_q[c] <= cnt_q[c] + 1'b1; // wraps to zero
      end
    end

    // write filtering keeps illegal combinations out of the register
    always_comb begin
      wctl = ictsc_pkg::ictsc_ctrl_t'(hwdata[`ICTSC_CTRL_W-1:0]);
      if (wctl.src == ictsc_pkg::ICTSC_SRC_UNDIV) begin
        wctl.cnt_edge = ictsc_pkg::ICTSC_EDGE_RISE;
      end
      if (wctl.mode == ictsc_pkg::ICTSC_MODE_FOLLOW) begin
        if (ctrl_q[P].mode != ictsc_pkg::ICTSC_MODE_MASTER) begin
          wctl.mode = ictsc_pkg::ICTSC_MODE_INDEP;
        end else begin
          wctl.clr = ictsc_pkg::ICTSC_CLR_SYNC;
        end
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        ctrl_q[c]     <= ictsc_pkg::ictsc_ctrl_t'(`ICTSC_CTRL_RST);
        ctrl_q[c].run <= RUN_AT_RESET;
      end else if (wr & ch_hit(addr_q, c, `ICTSC_OFS_CTRL)) begin
        ctrl_q[c] <= wctl;
      end
    end

    assign ev_set[`ICTSC_EV_PER_CH*c + `ICTSC_EV_OVF] =
        tick[c] & ~load[c] & ~clr_now[c] & (&cnt_q[c]);
    assign ev_set[`ICTSC_EV_PER_CH*c + `ICTSC_EV_CAP0] = cap_ev[2*c];
    assign ev_set[`ICTSC_EV_PER_CH*c + `ICTSC_EV_CAP1] = cap_ev[2*c+1];

    // ********************************************************
    // checks
    // ********************************************************
    chk_undiv_rise: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ctrl_q[c].src == ictsc_pkg::ICTSC_SRC_UNDIV |->
        ctrl_q[c].cnt_edge == ictsc_pkg::ICTSC_EDGE_RISE)
      else $error("undivided source with non-rising edge");

    chk_fall_only: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ctrl_q[c].run && ctrl_q[c].src == ictsc_pkg::ICTSC_SRC_PIN &&
      ctrl_q[c].cnt_edge == ictsc_pkg::ICTSC_EDGE_FALL && cnt_rise[c] &&
      !load[c] && !clr_now[c] |=> $stable(cnt_q[c]))
      else $error("falling-edge counter moved on rising edge");

    chk_stop_holds: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !ctrl_q[c].run && !load[c] |=> $stable(cnt_q[c]))
      else $error("stopped counter changed");

    chk_indep_pair: assert property (
      @(posedge hclk) disable iff (!hresetn)
      cnt_wr[P] && !pair_on[c] && !cnt_wr[c] && !tick[c] &&
      !clr_now[c] |=> $stable(cnt_q[c]))
      else $error("independent counter followed partner write");

    chk_sync_preset: assert property (
      @(posedge hclk) disable iff (!hresetn)
      cnt_wr[c] && pair_on[c] |=> cnt_q[P] == cnt_q[c])
      else $error("paired counters differ after preset");

    chk_follow_clr: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ctrl_q[c].mode == ictsc_pkg::ICTSC_MODE_FOLLOW |->
        ctrl_q[c].clr == ictsc_pkg::ICTSC_CLR_SYNC)
      else $error("follower without sync clearing");

    chk_no_clear: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ctrl_q[c].clr == ictsc_pkg::ICTSC_CLR_NONE && tick[c] &&
      !load[c] |=> cnt_q[c] == $past(cnt_q[c]) + 1'b1)
      else $error("counter cleared with clearing disabled");

    chk_cap_clear: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ctrl_q[c].clr == ictsc_pkg::ICTSC_CLR_CAP0 && cap_ev[2*c] &&
      !load[c] |=> cnt_q[c] == '0)
      else $error("capture did not clear counter");

    chk_sync_clear: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ctrl_q[c].clr == ictsc_pkg::ICTSC_CLR_SYNC && pair_on[c] &&
      own_fire[P] && !load[c] |=> cnt_q[c] == '0)
      else $error("partner clear not applied");

    chk_wrap_flag: assert property (
      @(posedge hclk) disable iff (!hresetn)
      tick[c] && (&cnt_q[c]) && !load[c] && !clr_now[c] |=>
        cnt_q[c] == '0 && status_q[`ICTSC_EV_PER_CH*c + `ICTSC_EV_OVF])
      else $error("overflow wrap or flag missing");
  end

  // ********************************************************
  // capture store
  // ********************************************************
  ictsc_capmem #(
    .WORDS (2 * NCH),
    .WIDTH (CW),
    .AW    (MAW)
  ) u_capmem (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (cap_ev),
    .wdata   (cap_data),
    .raddr   (MAW'({haddr[7:5], haddr[2]})),
    .rdata_q (cap_rdata)
  );

  // ********************************************************
  // interrupt status and mask
  // ********************************************************
  logic [NEV-1:0] status_d;
  logic [NEV-1:0] mask_q;
  logic [NEV-1:0] w1c;
  logic           irq_q;

  assign w1c = (wr & glb_hit(addr_q, `ICTSC_OFS_STAT)) ?
               hwdata[NEV-1:0] : '0;
  // a new event in the clearing cycle survives
  assign status_d = (status_q & ~w1c) | ev_set;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= '0;
    end else if (wr & glb_hit(addr_q, `ICTSC_OFS_MASK)) begin
      mask_q <= hwdata[NEV-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_d & mask_q);
    end
  end

  assign irq = irq_q;

  // ********************************************************
  // read data
  // ********************************************************
  logic [31:0] rd_val;

  always_comb begin
    rd_val = 32'h0;
    if (glb_hit(addr_q, `ICTSC_OFS_STAT)) begin
      rd_val = 32'(status_q);
    end else if (glb_hit(addr_q, `ICTSC_OFS_MASK)) begin
      rd_val = 32'(mask_q);
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (ch_hit(addr_q, c, `ICTSC_OFS_CTRL)) begin
          rd_val = 32'(ctrl_q[c]);
        end else if (ch_hit(addr_q, c, `ICTSC_OFS_CNT)) begin
          rd_val = 32'(cnt_q[c]);
        end else if (ch_hit(addr_q, c, `ICTSC_OFS_CAP0) ||
                     ch_hit(addr_q, c, `ICTSC_OFS_CAP1)) begin
          rd_val = 32'(cap_rdata);
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0;
    end else if (pend_q & ~wr_q) begin
      hrdata_q <= rd_val;
    end
  end

  // ********************************************************
  // bus and interrupt checks
  // ********************************************************
  sequence s_take;
    acc;
  endsequence

  sequence s_data_phase;
    !hready_q ##1 hready_q;
  endsequence

  chk_bus_wait: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_take |=> s_data_phase)
    else $error("data phase not exactly one wait state");

  chk_irq_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 irq_q == |(status_q & $past(mask_q)))
    else $error("interrupt not gated by mask");

  chk_cap_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cap_ev[0] |=> status_q[`ICTSC_EV_CAP0])
    else $error("capture flag not set");

endmodule

// ### verification/ictsc_pin_model.sv
`timescale 1ns/1ps

// ****
// far-side pin source
// ****
// these pins are always driven, so there is no released level to model
module ictsc_pin_model #(
  parameter int NCH = 4
) (
  input  wire logic             hclk,
  output logic      [NCH-1:0]   count_pin,
  output logic      [2*NCH-1:0] cap_pin
);
  // 8 cycles per level: sync needs 3, update 1, the rest is margin
  localparam int HOLD = 8;

  initial begin
    count_pin = '0;
    cap_pin   = '0;
  end

  // n whole pulses; every level is held HOLD cycles
  task automatic pulse(input bit cap, input int k, input int n);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge hclk);
      if (cap) begin
        cap_pin[k] <= ~cap_pin[k];
      end else begin
        count_pin[k] <= ~count_pin[k];
      end
      repeat (HOLD - 1) @(posedge hclk);
    end
  endtask
endmodule

// ### verification/ictsc_top_bench.sv
`timescale 1ns/1ps
`include "ictsc_defines.svh"

module ictsc_top_bench;
  localparam int           NCH   = 4;
  localparam int           CW    = 16;
  localparam int           LIMIT = 20000;
  localparam logic [7:0]   CTRL  = 8'(`ICTSC_OFS_CTRL);
  localparam logic [7:0]   CNT   = 8'(`ICTSC_OFS_CNT);
  localparam logic [7:0]   CAP0  = 8'(`ICTSC_OFS_CAP0);
  localparam logic [7:0]   CAP1  = 8'(`ICTSC_OFS_CAP1);
  localparam logic [7:0]   STAT  = `ICTSC_OFS_STAT;
  localparam logic [7:0]   MASK  = `ICTSC_OFS_MASK;

  logic                    hclk;
  logic                    hresetn;
  logic                    hsel;
  logic       [31:0]       haddr;
  logic       [1:0]        htrans;
  logic                    hwrite;
  logic       [2:0]        hsize;
  logic       [31:0]       hwdata;
  logic                    hreadyout;
  logic       [31:0]       hrdata;
  logic                    hresp;
  logic       [NCH-1:0]    count_pin;
  logic       [2*NCH-1:0]  cap_pin;
  logic                    irq;
  logic       [31:0]       rdat;
  int                      mismatches;
  int                      num_checks;
  int                      cycles;

  ictsc_top #(.NCH(NCH), .CW(CW), .RUN_AT_RESET(1'b1)) ictsc_top_i (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .count_pin (count_pin),
    .cap_pin   (cap_pin),
    .irq       (irq)
  );

  ictsc_pin_model #(.NCH(NCH)) ictsc_pin_model_i (
    .hclk      (hclk),
    .count_pin (count_pin),
    .cap_pin   (cap_pin)
  );

  // ****
  // clock, timeout, verdict
  // ****
  always #2.5 hclk = ~hclk;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      $display("[ERR] %0t run did not finish", $time);
      report_and_stop();
    end
  end

  // ****
  // bus access
  // ****
  function automatic logic [31:0] ra(input int c, input logic [7:0] ofs);
    return 32'(c * 32) + {24'h0, ofs};
  endfunction

  // one single transfer; waits on hready in both phases
  task automatic bus(input logic [31:0] a, input logic wr,
                     input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input int c, input logic [7:0] o, input logic [31:0] d);
    bus(ra(c, o), 1'b1, d);
  endtask

  task automatic rd(input int c, input logic [7:0] o, input logic [31:0] e);
    bus(ra(c, o), 1'b0, 32'h0);
    check(rdat, e);
  endtask

  // irq settles a few edges after the causing write
  task automatic chk_irq(input logic e);
    repeat (3) @(posedge hclk);
    check({31'h0, irq}, {31'h0, e});
  endtask

  // ****
  // test sequence
  // ****
  initial begin
    hclk       = 1'b0;
    hresetn    = 1'b0;
    hsel       = 1'b0;
    haddr      = 32'h0;
    htrans     = 2'b00;
    hwrite     = 1'b0;
    hsize      = 3'b010;
    hwdata     = 32'h0;
    mismatches = 0;
    num_checks = 0;
    cycles     = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(0, CTRL, 32'h001);
    rd(0, 8'h10, 32'h0);
    check({31'h0, hresp}, 32'h0);
    // undivided source with both-edge request: still one count per hclk
    wr(0, CTRL, 32'h009);
    rd(0, CTRL, 32'h001);
    wr(0, CNT, 32'h0);
    repeat (20) @(posedge hclk);
    bus(ra(0, CNT), 1'b0, 32'h0);
    num_checks++;
    if (rdat < 32'd20 || rdat > 32'd40) begin
      mismatches++;
      $display("[ERR] %0t undivided count %0d", $time, rdat);
    end
    // rise, fall, both on the pin source: 3 pulses
    for (int e = 0; e < 3; e++) begin
      wr(1, CTRL, 32'h003 | 32'(e << 2));
      wr(1, CNT, 32'h0);
      ictsc_pin_model_i.pulse(1'b0, 1, 3);
      rd(1, CNT, (e == 2) ? 32'd6 : 32'd3);
    end
    // unpaired channels keep their own counts
    wr(1, CTRL, 32'h0);
    wr(2, CTRL, 32'h0);
    wr(1, CNT, 32'h42);
    wr(0, CTRL, 32'h443);
    wr(0, CNT, 32'h1234);
    rd(1, CNT, 32'h42);
    // capture 0 clears, capture 1 on falling edge does not
    wr(0, MASK, 32'h2);
    ictsc_pin_model_i.pulse(1'b1, 0, 1);
    rd(0, CAP0, 32'h1234);
    rd(0, CNT, 32'h0);
    rd(0, STAT, 32'h2);
    chk_irq(1'b1);
    wr(0, STAT, 32'h2);
    chk_irq(1'b0);
    wr(0, CNT, 32'h55);
    ictsc_pin_model_i.pulse(1'b1, 1, 1);
    rd(0, CAP1, 32'h55);
    rd(0, CNT, 32'h55);
    rd(0, STAT, 32'h4);
    chk_irq(1'b0);
    wr(0, STAT, 32'h4);
    // clearing disabled
    wr(0, CTRL, 32'h003);
    wr(0, CNT, 32'h77);
    ictsc_pin_model_i.pulse(1'b1, 0, 1);
    rd(0, CAP0, 32'h77);
    rd(0, CNT, 32'h77);
    wr(0, STAT, 32'h2);
    // overflow wrap, masked then unmasked
    wr(0, MASK, 32'h0);
    wr(1, CTRL, 32'h003);
    wr(1, CNT, 32'((1 << CW) - 1));
    ictsc_pin_model_i.pulse(1'b0, 1, 1);
    rd(1, CNT, 32'h0);
    rd(0, STAT, 32'h8);
    chk_irq(1'b0);
    wr(0, MASK, 32'h8);
    chk_irq(1'b1);
    wr(0, STAT, 32'h8);
    chk_irq(1'b0);
    // follower without a master partner falls back to independent
    wr(2, CTRL, 32'h020);
    bus(ra(2, CTRL), 1'b0, 32'h0);
    check(rdat & 32'h30, 32'h0);
    wr(2, CNT, 32'h9);
    // master configured first, then the follower with sync clearing
    wr(0, CTRL, 32'h053);
    wr(1, CTRL, 32'h0e3);
    wr(0, CNT, 32'h321);
    rd(1, CNT, 32'h321);
    rd(2, CNT, 32'h9);
    wr(1, CNT, 32'h500);
    rd(0, CNT, 32'h500);
    ictsc_pin_model_i.pulse(1'b1, 0, 1);
    rd(0, CNT, 32'h0);
    rd(1, CNT, 32'h0);
    rd(2, CNT, 32'h9);
    // edge code 3 counts as rise; capture 1 on both edges clears
    wr(2, CTRL, 32'h88f);
    wr(2, CNT, 32'h0);
    ictsc_pin_model_i.pulse(1'b0, 2, 2);
    rd(2, CNT, 32'd2);
    ictsc_pin_model_i.pulse(1'b1, 5, 1);
    rd(2, CAP1, 32'h0);
    rd(2, CNT, 32'h0);
    rd(0, STAT, 32'h102);
    report_and_stop();
  end
endmodule
